// File: hw/chain_host.sv
// Host controller for two chained 64x4 self-timed queue units.
// Assumes the upstream input and downstream output of the chain are on pins;
// the link between the two units is wired unit to unit with no glue.
//
// Behaviour
// RULE1: Chain acts as one 128x4 queue
// RULE2: Upstream output pulse strobes downstream input
// RULE3: Pulse timing meets downstream input needs
// RULE4: Full chain read moves one word across
// RULE5: Vacancy reaches upstream input, ready rises
// RULE6: Downstream input ready recovers by itself
// RULE7: Upstream output ready falls during transfer
// RULE8: Output ready rises, then data valid
// RULE9: Upstream input ready rises after bubble-up
// RULE10: Clear empties both, flags to idle
// RULE11: Held shift-out pulses ready per word
// RULE12: After 64 writes downstream full
// RULE13: From 65th word upstream output ready high
// RULE14: After 128 writes further shifts ignored
// RULE15: Held shift-in absorbs one word per vacancy
// RULE16: After 63 more reads upstream output low
// RULE17: Reads on empty chain do nothing
// RULE18: Width expansion ANDs side-by-side ready flags
// RULE19: Extra flag logic only for held strobes
// RULE20: Shift-in into full store is ignored
// RULE21: Input ready low while word accepted
// RULE22: One common clear for all units
// RULE23: Flags agree with each unit's count
`timescale 1ns/1ps
module chain_host (
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    input  wire logic                          clear_req_in,
    input  wire logic [chain_pkg::WORD_W-1:0]  wr_data_in,
    input  wire logic                          wr_valid_in,
    output logic                               wr_ready_out,
    output logic      [chain_pkg::WORD_W-1:0]  rd_data_out,
    output logic                               rd_valid_out,
    input  wire logic                          rd_ready_in,
    output chain_pkg::write_pins_t             wr_pins_out,
    output chain_pkg::read_pins_t              rd_pins_out,
    input  wire logic                          upstream_input_ready_in,
    input  wire logic                          downstream_output_ready_in,
    input  wire logic [chain_pkg::WORD_W-1:0]  data_out_bits_in
);
    // -----------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------
    // Three stages; a change counts once stages two and three agree
    localparam int unsigned SYNC_W = 2 + chain_pkg::WORD_W;
    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    logic [SYNC_W-1:0] s3_r;
    logic [SYNC_W-1:0] stable_r;
    logic [SYNC_W-1:0] s1_nxt;
    logic [SYNC_W-1:0] stable_nxt;
    logic              in_rdy;
    logic              out_rdy;
    logic [chain_pkg::WORD_W-1:0] q_bits;

    always_comb
    begin
        s1_nxt = {upstream_input_ready_in, downstream_output_ready_in, data_out_bits_in};
    end

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_filt
            always_comb
            begin
                stable_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : stable_r[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            stable_r <= '0;
        end
        else
        begin
            s1_r     <= s1_nxt;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= stable_nxt;
        end
    end

    always_comb
    begin
        in_rdy  = stable_r[SYNC_W-1]; // One unit wide, so the combined flag is the flag itself [RULE18]
        out_rdy = stable_r[SYNC_W-2];
        q_bits  = stable_r[chain_pkg::WORD_W-1:0];
    end

    // -----------------------------------------------
    // Write side: buffer, then strobe upstream input
    // -----------------------------------------------
    logic [chain_pkg::WORD_W-1:0] buf_data;
    logic                         buf_valid;
    logic                         buf_take;
    chain_pkg::wr_state_t         wst_r;
    chain_pkg::wr_state_t         wst_nxt;
    logic [chain_pkg::TIMER_W-1:0] wtm_r;
    logic [chain_pkg::TIMER_W-1:0] wtm_nxt;
    logic [chain_pkg::WORD_W-1:0] din_r;
    logic [chain_pkg::WORD_W-1:0] din_nxt;
    logic                         si_r;
    logic                         si_nxt;
    logic                         mc_n_r;
    logic                         mc_n_nxt;

    word_fifo #(
        .WIDTH (chain_pkg::WORD_W),
        .DEPTH (chain_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .clear_in     (clear_req_in),
        .wr_data_in   (wr_data_in),
        .wr_valid_in  (wr_valid_in),
        .wr_ready_out (wr_ready_out),
        .rd_data_out  (buf_data),
        .rd_valid_out (buf_valid),
        .rd_ready_in  (buf_take)
    );

    always_comb
    begin
        wst_nxt  = wst_r;
        wtm_nxt  = (wtm_r != chain_pkg::TIMER_ZERO) ? wtm_r - chain_pkg::TIMER_ONE : wtm_r;
        din_nxt  = din_r;
        si_nxt   = si_r;
        mc_n_nxt = mc_n_r;
        buf_take = 1'b0;
        unique case (wst_r)
            chain_pkg::WR_CLEAR:
            begin
                // One clear drives both units together [RULE22] [RULE10]
                if (wtm_r == chain_pkg::TIMER_ZERO)
                begin
                    mc_n_nxt = 1'b1;
                    wtm_nxt  = chain_pkg::TIMER_W'(chain_pkg::RECOVERY_CYC);
                    wst_nxt  = chain_pkg::WR_LOW;
                end
            end
            chain_pkg::WR_IDLE:
            begin
                // Strobe only on ready, never held ahead [RULE14] [RULE19] [RULE20] [RULE23]
                if (buf_valid && in_rdy)
                begin
                    buf_take = 1'b1;
                    din_nxt  = buf_data;
                    si_nxt   = 1'b1;
                    wtm_nxt  = chain_pkg::TIMER_W'(chain_pkg::SHIFT_HIGH_CYC);
                    wst_nxt  = chain_pkg::WR_HIGH;
                end
            end
            chain_pkg::WR_HIGH:
            begin
                // Hold strobe until busy shows, then drop it [RULE21] [RULE15]
                if (wtm_r == chain_pkg::TIMER_ZERO && !in_rdy)
                begin
                    si_nxt  = 1'b0;
                    wtm_nxt = chain_pkg::TIMER_W'(chain_pkg::SHIFT_LOW_CYC);
                    wst_nxt = chain_pkg::WR_LOW;
                end
            end
            chain_pkg::WR_LOW:
            begin
                // Wait for the vacancy to bubble up before next word [RULE9] [RULE5]
                if (wtm_r == chain_pkg::TIMER_ZERO)
                begin
                    wst_nxt = chain_pkg::WR_IDLE;
                end
            end
        endcase
        if (clear_req_in)
        begin
            mc_n_nxt = 1'b0;
            si_nxt   = 1'b0;
            wtm_nxt  = chain_pkg::TIMER_W'(chain_pkg::CLEAR_LOW_CYC);
            wst_nxt  = chain_pkg::WR_CLEAR;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wst_r  <= chain_pkg::WR_CLEAR;
            wtm_r  <= chain_pkg::TIMER_W'(chain_pkg::CLEAR_LOW_CYC);
            din_r  <= '0;
            si_r   <= 1'b0;
            mc_n_r <= 1'b0;
        end
        else
        begin
            wst_r  <= wst_nxt;
            wtm_r  <= wtm_nxt;
            din_r  <= din_nxt;
            si_r   <= si_nxt;
            mc_n_r <= mc_n_nxt;
        end
    end

    // -----------------------------------------------
    // Read side: strobe downstream output
    // -----------------------------------------------
    // Only one word in flight; the chain itself is the deep store [RULE1]
    chain_pkg::rd_state_t          rst_s_r;
    chain_pkg::rd_state_t          rst_s_nxt;
    logic [chain_pkg::TIMER_W-1:0] rtm_r;
    logic [chain_pkg::TIMER_W-1:0] rtm_nxt;
    logic [chain_pkg::WORD_W-1:0]  rdat_r;
    logic [chain_pkg::WORD_W-1:0]  rdat_nxt;
    logic                          rv_r;
    logic                          rv_nxt;
    logic                          so_r;
    logic                          so_nxt;

    always_comb
    begin
        rst_s_nxt = rst_s_r;
        rtm_nxt   = (rtm_r != chain_pkg::TIMER_ZERO) ? rtm_r - chain_pkg::TIMER_ONE : rtm_r;
        rdat_nxt  = rdat_r;
        rv_nxt    = (rv_r && rd_ready_in) ? 1'b0 : rv_r;
        so_nxt    = so_r;
        unique case (rst_s_r)
            chain_pkg::RD_WAIT:
            begin
                // Data settle one delay after ready; never read an empty chain [RULE8] [RULE17]
                // Synced flag lags a clear by a few edges, so no read while clearing
                if (out_rdy && !rv_r && mc_n_r)
                begin
                    rtm_nxt   = chain_pkg::TIMER_W'(chain_pkg::SHIFT_LOW_CYC);
                    rst_s_nxt = chain_pkg::RD_IDLE;
                end
            end
            chain_pkg::RD_IDLE:
            begin
                if (rtm_r == chain_pkg::TIMER_ZERO)
                begin
                    rdat_nxt  = q_bits;
                    rv_nxt    = 1'b1;
                    so_nxt    = 1'b1;
                    rtm_nxt   = chain_pkg::TIMER_W'(chain_pkg::SHIFT_HIGH_CYC);
                    rst_s_nxt = chain_pkg::RD_HIGH;
                end
            end
            chain_pkg::RD_HIGH:
            begin
                // Unit drops ready while its output stage is busy [RULE11] [RULE4]
                if (rtm_r == chain_pkg::TIMER_ZERO && !out_rdy)
                begin
                    so_nxt    = 1'b0;
                    rtm_nxt   = chain_pkg::TIMER_W'(chain_pkg::SHIFT_LOW_CYC);
                    rst_s_nxt = chain_pkg::RD_LOW;
                end
            end
            chain_pkg::RD_LOW:
            begin
                if (rtm_r == chain_pkg::TIMER_ZERO)
                begin
                    rst_s_nxt = chain_pkg::RD_WAIT;
                end
            end
        endcase
        if (clear_req_in)
        begin
            so_nxt    = 1'b0;
            rv_nxt    = 1'b0;
            rst_s_nxt = chain_pkg::RD_WAIT;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rst_s_r <= chain_pkg::RD_WAIT;
            rtm_r   <= '0;
            rdat_r  <= '0;
            rv_r    <= 1'b0;
            so_r    <= 1'b0;
        end
        else
        begin
            rst_s_r <= rst_s_nxt;
            rtm_r   <= rtm_nxt;
            rdat_r  <= rdat_nxt;
            rv_r    <= rv_nxt;
            so_r    <= so_nxt;
        end
    end

    always_comb
    begin
        wr_pins_out.shift_in       = si_r;
        wr_pins_out.master_clear_n = mc_n_r;
        wr_pins_out.data_in_bits   = din_r;
        rd_pins_out.shift_out      = so_r;
        rd_data_out                = rdat_r;
        rd_valid_out               = rv_r;
    end
endmodule

// File: hw/chain_pkg.sv
// Constants and carrier types for the cascaded queue controller.
// Assumes a 250 MHz clock and two chained 64x4 units on the pins.
package chain_pkg;
    localparam int unsigned WORD_W        = 4;
    localparam int unsigned UNIT_DEPTH    = 64;
    localparam int unsigned CHAIN_DEPTH   = 128;
    localparam int unsigned BUF_DEPTH     = 8;
    localparam int unsigned CLK_PERIOD_NS = 4;
    // Minimum pin pulse widths, high and low, and clear recovery time, in ns
    localparam int unsigned SHIFT_HIGH_NS = 40;
    localparam int unsigned SHIFT_LOW_NS  = 40;
    localparam int unsigned CLEAR_LOW_NS  = 40;
    localparam int unsigned RECOVERY_NS   = 40;
    localparam int unsigned SHIFT_HIGH_CYC = (SHIFT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SHIFT_LOW_CYC  = (SHIFT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CLEAR_LOW_CYC  = (CLEAR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVERY_CYC   = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W        = 8;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;
    localparam logic [TIMER_W-1:0] TIMER_ONE  = 8'h01;

    typedef struct packed {
        logic               shift_in;
        logic               master_clear_n;
        logic [WORD_W-1:0]  data_in_bits;
    } write_pins_t;

    typedef struct packed {
        logic               shift_out;
    } read_pins_t;

    typedef enum logic [1:0] {
        WR_CLEAR = 2'b00,
        WR_IDLE  = 2'b01,
        WR_HIGH  = 2'b10,
        WR_LOW   = 2'b11
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_WAIT = 2'b00,
        RD_HIGH = 2'b01,
        RD_LOW  = 2'b10,
        RD_IDLE = 2'b11
    } rd_state_t;
endpackage

// File: hw/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data leave from a register.
`timescale 1ns/1ps
module word_fifo #(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             clear_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_ONE   = (AW+1)'(1);
    localparam logic [AW:0] CNT_FULL  = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ZERO  = '0;
    localparam logic [AW-1:0] PTR_ONE = AW'(1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    wp_nxt;
    logic [AW-1:0]    rp_r;
    logic [AW-1:0]    rp_nxt;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;
    logic             ov_r;
    logic             ov_nxt;
    logic             push;
    logic             load;

    // -----------------------------------------------
    // Control
    // -----------------------------------------------
    always_comb
    begin
        wr_ready_out = (cnt_r != CNT_FULL);
        rd_valid_out = ov_r;
        rd_data_out  = out_r;
        push    = wr_valid_in && wr_ready_out;
        load    = (cnt_r != CNT_ZERO) && (!ov_r || rd_ready_in);
        wp_nxt  = push ? wp_r + PTR_ONE : wp_r;
        rp_nxt  = load ? rp_r + PTR_ONE : rp_r;
        cnt_nxt = cnt_r;
        if (push && !load)
        begin
            cnt_nxt = cnt_r + CNT_ONE;
        end
        else if (load && !push)
        begin
            cnt_nxt = cnt_r - CNT_ONE;
        end
        out_nxt = load ? mem_r[rp_r] : out_r;
        ov_nxt  = load ? 1'b1 : (rd_ready_in ? 1'b0 : ov_r);
        if (clear_in)
        begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = CNT_ZERO;
            ov_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            out_r <= '0;
            ov_r  <= 1'b0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
            ov_r  <= ov_nxt;
        end
    end

    // Storage has no reset; only counted words are read
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_r[wp_r] <= wr_data_in;
        end
    end
endmodule

// File: testbench/chain_host_asserts.sv
// Concurrent checks on the pins and user ports of the chained queue host.
// Assumes one clock and the async reset of chain_host; bound below.
`timescale 1ns/1ps
module chain_host_asserts (
    input wire logic                         clk_in,
    input wire logic                         rst_in,
    input wire logic                         clear_req_in,
    input wire logic                         wr_ready_out,
    input wire logic [chain_pkg::WORD_W-1:0] rd_data_out,
    input wire logic                         rd_valid_out,
    input wire logic                         rd_ready_in,
    input wire chain_pkg::write_pins_t       wr_pins_out,
    input wire chain_pkg::read_pins_t        rd_pins_out,
    input wire logic                         upstream_input_ready_in,
    input wire logic                         downstream_output_ready_in
);
    logic si;
    logic so;
    logic mc;
    assign si = wr_pins_out.shift_in;
    assign so = rd_pins_out.shift_out;
    assign mc = wr_pins_out.master_clear_n;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // --------------------------------
    // Pin protocol
    // --------------------------------
    AST_CLEAR_FOLLOWS: assert property (clear_req_in |=> !mc) else $error("clear pin not low after request");
    AST_CLEAR_WIDTH: assert property ($rose(mc) |-> !$past(mc, 10)) else $error("clear pulse too short");
    AST_NO_SHIFT_IN_CLEAR: assert property (!mc && $past(!mc) |-> !si) else $error("shift in during clear");
    // Unit drops its flag on the strobe edge, so judge the flag as it stood before
    AST_SI_WHEN_READY: assert property ($rose(si) |-> $past(upstream_input_ready_in))
        else $error("shift in while busy");
    // Clear may cut a strobe short, so widths are judged outside clears
    AST_SI_WIDTH: assert property (disable iff (rst_in || !mc) $rose(si) |-> si[*8] ##1 si[*2])
        else $error("shift in strobe too short");
    AST_SI_GAP: assert property ($fell(si) |-> !si[*8] ##1 !si[*2]) else $error("shift in gap too short");
    AST_SO_WHEN_READY: assert property ($rose(so) |-> $past(downstream_output_ready_in))
        else $error("shift out while empty");
    AST_SO_CAPTURE: assert property ($rose(so) |-> $rose(rd_valid_out)) else $error("shift out without capture");
    AST_SO_WIDTH: assert property (disable iff (rst_in || !mc) $rose(so) |-> so[*8] ##1 so[*2])
        else $error("shift out strobe too short");
    AST_READ_HOLDS: assert property (
        rd_valid_out && !rd_ready_in && !clear_req_in |=> rd_valid_out && $stable(rd_data_out))
        else $error("read word dropped");
    AST_DATA_HOLDS: assert property (si && $past(si) |-> $stable(wr_pins_out.data_in_bits))
        else $error("write data moved in strobe");
    cover property ($rose(si));
    cover property ($rose(so));
    cover property (!wr_ready_out);
    cover property ($rose(mc));
endmodule
bind chain_host chain_host_asserts u_asserts (.clk_in(clk_in), .rst_in(rst_in), .clear_req_in(clear_req_in),
    .wr_ready_out(wr_ready_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
    .wr_pins_out(wr_pins_out), .rd_pins_out(rd_pins_out), .upstream_input_ready_in(upstream_input_ready_in),
    .downstream_output_ready_in(downstream_output_ready_in));

// File: testbench/chain_model.sv
// Behavioural model of two chained 64x4 self-timed queue units.
// Assumes the host pins of chain_host; slow_in stretches both ready-flag delays, not the 8 ns data lag.
`timescale 1ns/1ps
module chain_model (
    input  wire chain_pkg::write_pins_t  wr_pins_in,
    input  wire logic                    shift_out_in,
    input  wire logic                    slow_in,
    output logic                         upstream_input_ready_out,
    output logic                         downstream_output_ready_out,
    output logic [chain_pkg::WORD_W-1:0] data_out_bits_out
);
    logic [chain_pkg::WORD_W-1:0] store[$];
    int unsigned                  dly;
    always_comb dly = slow_in ? 300 : 30;
    initial
    begin
        upstream_input_ready_out = 1'b0;
        downstream_output_ready_out = 1'b0;
        data_out_bits_out = 4'h0;
    end
    // --------------------------------
    // Common clear empties both units
    // --------------------------------
    always @(negedge wr_pins_in.master_clear_n)
    begin
        store.delete();
        upstream_input_ready_out = 1'b1;
        downstream_output_ready_out = 1'b0;
        data_out_bits_out = 4'h0;
    end
    always @(posedge wr_pins_in.shift_in)
        if (wr_pins_in.master_clear_n && upstream_input_ready_out && store.size() < chain_pkg::CHAIN_DEPTH)
        begin
            store.push_back(wr_pins_in.data_in_bits);
            upstream_input_ready_out = 1'b0;
        end
    // Vacancy bubbles up only after the strobe falls
    always
    begin
        wait (!upstream_input_ready_out && !wr_pins_in.shift_in && store.size() < chain_pkg::CHAIN_DEPTH);
        #(dly);
        if (!wr_pins_in.shift_in && store.size() < chain_pkg::CHAIN_DEPTH)
            upstream_input_ready_out = 1'b1;
    end
    always @(posedge shift_out_in)
        if (downstream_output_ready_out && store.size() > 0)
        begin
            void'(store.pop_front());
            downstream_output_ready_out = 1'b0;
        end
    // Flag leads the data, so an early sampler sees the old word
    always
    begin
        wait (!downstream_output_ready_out && !shift_out_in && store.size() > 0);
        #(dly);
        if (!shift_out_in && store.size() > 0)
        begin
            downstream_output_ready_out = 1'b1;
            #8 data_out_bits_out = store[0];
        end
    end
endmodule

// File: testbench/test_chain_host.sv
// Self-checking bench for chain_host against the chained queue model.
// Assumes the 250 MHz clock and the host's 8-word input buffer.
`timescale 1ns/1ps
module test_chain_host;
    logic                         clk_in = 1'b0;
    logic                         rst_in = 1'b1;
    logic                         clear_req_in = 1'b0;
    logic                         wr_valid_in = 1'b0;
    logic                         rd_ready_in = 1'b0;
    logic                         slow = 1'b0;
    logic [chain_pkg::WORD_W-1:0] wr_data_in = 4'h0;
    logic [chain_pkg::WORD_W-1:0] rd_data_out;
    logic [chain_pkg::WORD_W-1:0] data_out_bits_in;
    logic                         wr_ready_out;
    logic                         rd_valid_out;
    logic                         upstream_input_ready_in;
    logic                         downstream_output_ready_in;
    chain_pkg::write_pins_t       wr_pins_out;
    chain_pkg::read_pins_t        rd_pins_out;
    logic [chain_pkg::WORD_W-1:0] expect_q[$];
    int                           errors = 0;
    int                           total_checks = 0;
    int                           seed = 32'had7bad7d;
    int                           rd_mode = 0;
    int                           so_count = 0;
    int                           n;
    always #2 clk_in = ~clk_in;
    chain_host dut_u (.clk_in(clk_in), .rst_in(rst_in), .clear_req_in(clear_req_in), .wr_data_in(wr_data_in),
        .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in), .wr_pins_out(wr_pins_out), .rd_pins_out(rd_pins_out),
        .upstream_input_ready_in(upstream_input_ready_in), .downstream_output_ready_in(downstream_output_ready_in),
        .data_out_bits_in(data_out_bits_in));
    chain_model model_u (.wr_pins_in(wr_pins_out), .shift_out_in(rd_pins_out.shift_out), .slow_in(slow),
        .upstream_input_ready_out(upstream_input_ready_in), .downstream_output_ready_out(downstream_output_ready_in),
        .data_out_bits_out(data_out_bits_in));
    // --------------------------------
    // Checking helpers
    // --------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Ready is buffer state only, so it is settled at the falling edge
    task automatic write_words(input int count);
        for (int i = 0; i < count; i++)
        begin
            n = 0;
            while (wr_ready_out !== 1'b1 && n < 2000)
            begin
                @(negedge clk_in);
                n++;
            end
            if (n >= 2000)
                break;
            wr_data_in = 4'($random(seed));
            wr_valid_in = 1'b1;
            @(negedge clk_in);
        end
        wr_valid_in = 1'b0;
    endtask
    task automatic drain();
        n = 0;
        while (expect_q.size() != 0 && n < 40000)
        begin
            @(negedge clk_in);
            n++;
        end
        check("words left", 8'h00, 8'(expect_q.size()));
    endtask
    always @(negedge clk_in) rd_ready_in <= (rd_mode == 2) || (rd_mode == 1 && $random(seed) % 2 != 0);
    always @(posedge rd_pins_out.shift_out) so_count++;
    // Notes on writes, compares on reads; a clear drops every note
    always @(posedge clk_in)
        if (!rst_in && clear_req_in)
            expect_q.delete();
        else if (!rst_in && rd_valid_out === 1'b1 && rd_ready_in)
        begin
            if (expect_q.size() == 0)
                check("unexpected word", 8'h00, 8'hFF);
            else
                check("read word", {4'h0, expect_q.pop_front()}, {4'h0, rd_data_out});
        end
    always @(posedge clk_in)
        if (!rst_in && !clear_req_in && wr_valid_in && wr_ready_out === 1'b1)
            expect_q.push_back(wr_data_in);
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial
    begin
        repeat (12) @(negedge clk_in);
        check("clear pin in reset", 8'h00, {7'h00, wr_pins_out.master_clear_n});
        check("ready and valid in reset", 8'h02, {6'h00, wr_ready_out, rd_valid_out});
        rst_in = 1'b0;
        rd_mode = 1;
        write_words(24);
        drain();
        rd_mode = 0;
        write_words(200);
        check("chain words", 8'(chain_pkg::CHAIN_DEPTH), 8'(model_u.store.size()));
        check("full input ready", 8'h00, {6'h00, upstream_input_ready_in, wr_ready_out});
        slow = 1'b1;
        rd_mode = 2;
        drain();
        so_count = 0;
        repeat (300) @(negedge clk_in);
        check("reads on empty", 8'h00, 8'(so_count));
        slow = 1'b0;
        rd_mode = 0;
        write_words(30);
        clear_req_in = 1'b1;
        @(negedge clk_in);
        clear_req_in = 1'b0;
        @(negedge clk_in);
        check("clear pin", 8'h00, {7'h00, wr_pins_out.master_clear_n});
        repeat (60) @(negedge clk_in);
        check("words after clear", 8'h00, 8'(model_u.store.size()));
        check("valid after clear", 8'h00, {7'h00, rd_valid_out});
        rd_mode = 1;
        write_words(10);
        drain();
        test_done();
    end
    initial
    begin
        #400000;
        errors++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        test_done();
    end
endmodule
